// ===== afe_clock_prescaler.sv
// analog master clock prescaler, one-cycle enable per divided period
`timescale 1ns/100ps
`default_nettype none
module afe_clock_prescaler #(
  parameter int CNT_W = 3
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic [1:0] pre_sel,
  output logic tick
);
  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] last;

  // the counter must reach 7 for the divide-by-8 setting
  if (CNT_W < 3) begin : g_cnt_too_narrow
    $error("prescaler counter too narrow");
  end

  // terminal count is 2^sel - 1
  assign last = CNT_W'((1 << pre_sel) - 1);
  assign tick = (cnt_q >= last);

  // wrap on terminal count; a setting change lands at once via >=
  always_ff @(posedge clk) begin
    if (!resetn) begin
      cnt_q <= '0;
    end else if (tick) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_q + 1'b1;
    end
  end
endmodule
`default_nettype wire

// ===== afe_front_model.sv
// behavioural converter front end feeding the register bank
`timescale 1ns/100ps
`default_nettype none
module afe_front_model #(
  parameter int TICK_DIV = 4
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic conv_req,
  input wire logic [23:0] conv_value,
  output logic modulator_digital_clock_tick,
  output logic conv_done,
  output logic [23:0] conv_result,
  output logic modulator_bit
);
  int cnt;
  // modulator clock divider, free running after reset
  always_ff @(posedge clk) begin
    cnt <= (!resetn || cnt == TICK_DIV - 1) ? 0 : cnt + 1;
    modulator_digital_clock_tick <= resetn && cnt == TICK_DIV - 1;
  end
  // one-cycle result strobe; result bus churns outside it so stale data is not trusted
  always_ff @(posedge clk) begin
    conv_done <= resetn && conv_req;
    conv_result <= conv_req ? conv_value : ~conv_result;
    modulator_bit <= resetn && !modulator_bit;
  end
endmodule
`default_nettype wire

// ===== afe_regs_pkg.sv
// constants and register layout of the analog front end status/config bank
package afe_regs_pkg;
  // register indices; byte address is four times the index
  localparam logic [5:0] IDX_STATUS = 6'h0c;
  localparam logic [5:0] IDX_CFG_A = 6'h0d;
  localparam logic [5:0] IDX_CFG_B = 6'h0e;
  localparam logic [5:0] IDX_LOCK = 6'h1f;
  // serial map addresses used by the address counter
  localparam logic [4:0] MAP_DATA = 5'h00;
  localparam logic [4:0] MAP_MOD = 5'h08;
  localparam logic [4:0] MAP_GAIN = 5'h0b;
  localparam logic [4:0] MAP_STATUS = 5'h0c;
  localparam logic [4:0] MAP_CFG_B = 5'h0e;
  localparam logic [4:0] MAP_OFFCAL = 5'h0f;
  localparam logic [4:0] MAP_GAINCAL = 5'h10;
  localparam logic [4:0] MAP_LOCK = 5'h1f;
  // status register fields
  localparam int ST_RD_INC = 22;
  localparam int ST_WR_INC = 21;
  localparam int ST_FLOAT = 20;
  localparam int ST_CRC_W = 18;
  localparam int ST_DATA_W = 16;
  localparam int ST_LINK_CRC = 15;
  localparam int ST_INT_EN = 14;
  localparam int ST_MDAT = 11;
  localparam int ST_FLAG = 0;
  // config a fields
  localparam int CA_OFFCAL = 23;
  localparam int CA_GAINCAL = 22;
  localparam int CA_NOISE_INJECTION_STRENGTH = 20;
  localparam int CA_BIAS = 18;
  localparam int CA_PRE = 16;
  localparam int CA_OSR = 13;
  localparam int CA_TRIM = 0;
  // config b fields
  localparam int CB_SRST = 16;
  localparam int CB_SHDN = 8;
  localparam int CB_VREF = 7;
  localparam int CB_CLK = 6;
  // power-on values and writable masks
  localparam logic [23:0] ST_RESET = 24'ha10000;
  localparam logic [23:0] ST_WMASK = 24'hf7f800;
  localparam logic [23:0] CA_RESET = 24'h386050;
  localparam logic [23:0] CA_WMASK = 24'hffe0ff;
  localparam logic [23:0] CB_RESET = 24'h000040;
  localparam logic [23:0] CB_WMASK = 24'h0101c0;
  localparam logic [7:0] LOCK_PASSWORD = 8'ha5;
  localparam logic [15:0] CRC_RESET = 16'h0000;
  localparam logic [15:0] CRC_POLY = 16'h8005;
  // counts in modulator clock ticks
  localparam logic [4:0] GAIN_DELAY_TICKS = 5'd24;
  localparam logic [3:0] CRC_REFRESH_TICKS = 4'd10;
  localparam logic [12:0] OSR_BASE = 13'd32;
endpackage

// ===== afe_status_config_regs.sv
// status, communication and configuration register bank with apb access
//
// Design decision made here: the APB interface to the registers.
`timescale 1ns/100ps
`default_nettype none
module afe_status_config_regs (
  input wire logic clk,
  input wire logic resetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic modulator_digital_clock_tick,
  input wire logic conv_done,
  input wire logic [23:0] conv_result,
  input wire logic modulator_bit,
  input wire logic [4:0] link_addr,
  input wire logic [15:0] link_crc,
  output logic [4:0] link_next_read_addr,
  output logic [4:0] link_next_write_addr,
  output logic [31:0] link_crc_word,
  output logic link_crc_is_32,
  output logic link_checksum_enable,
  output logic [31:0] result_word,
  output logic [1:0] data_width,
  output logic data_ready_pin_o,
  output logic data_ready_pin_oe,
  output logic bitstream_out_pin_o,
  output logic bitstream_out_pin_oe,
  output logic offset_correct_enable,
  output logic gain_correct_enable,
  output logic [1:0] noise_injection_strength,
  output logic [1:0] bias_current_scale,
  output logic analog_master_clock,
  output logic [2:0] decimation_code,
  output logic [12:0] decimation_ratio,
  output logic [7:0] reference_tempco_trim,
  output logic channel_soft_reset,
  output logic channel_shutdown,
  output logic external_reference_select,
  output logic external_clock_select
);
  import afe_regs_pkg::*;

  logic [23:0] st_q, ca_q, cb_q, hold_q, rd_word, fmt_src;
  logic [7:0] lock_q;
  logic [15:0] map_checksum_value_q, crc_calc;
  logic [4:0] delay_q, nrd_q, nwr_q;
  logic [3:0] refresh_q;
  logic [31:0] prdata_q, crcw_q, res_q;
  logic [5:0] idx;
  logic crc_seen_q, irq_q, result_pending_flag_q, bit_q, mapped, access, wr;
  logic locked, conv_go, ready_evt, status_read;

  // checksum over the writable part of the map, msb first
  function automatic logic [15:0] map_crc(input logic [71:0] msg);
    logic [15:0] c;
    c = CRC_RESET;
    for (int i = 71; i >= 0; i--) begin
      c = (c[15] ^ msg[i]) ? ((c << 1) ^ CRC_POLY) : (c << 1);
    end
    return c;
  endfunction

  // loop start and end of the register group holding an address
  function automatic logic [9:0] group_of(input logic [4:0] a);
    if (a < MAP_MOD) begin
      return {MAP_DATA, MAP_DATA};
    end else if (a <= MAP_GAIN) begin
      return {MAP_MOD, MAP_GAIN};
    end else if (a <= MAP_CFG_B) begin
      return {MAP_STATUS, MAP_CFG_B};
    end else if (a <= MAP_GAINCAL) begin
      return {MAP_OFFCAL, MAP_GAINCAL};
    end
    return {MAP_LOCK, MAP_LOCK};
  endfunction

  // next read address for the four read increment modes
  function automatic logic [4:0] next_rd(input logic [1:0] m, input logic [4:0] a);
    logic [9:0] g;
    g = group_of(a);
    case (m)
      2'b11: return (a == MAP_LOCK) ? MAP_DATA : a + 5'd1;
      2'b10: begin
        if (a < MAP_MOD) begin
          return MAP_DATA;
        end
        return (a == MAP_LOCK) ? MAP_MOD : a + 5'd1;
      end
      2'b01: return (a == g[4:0]) ? g[9:5] : a + 5'd1;
      default: return a;
    endcase
  endfunction

  assign idx = paddr[7:2];
  assign mapped = (idx == IDX_STATUS) || (idx == IDX_CFG_A) ||
                  (idx == IDX_CFG_B) || (idx == IDX_LOCK);
  assign access = psel && penable;
  assign wr = access && pwrite && mapped;
  assign locked = (lock_q != LOCK_PASSWORD);
  assign status_read = access && !pwrite && (idx == IDX_STATUS);
  assign crc_calc = map_crc({st_q & ST_WMASK, ca_q, cb_q});

  // zero wait-state slave; unmapped addresses answer with an error
  assign pready = 1'b1;
  assign pslverr = access && !mapped;
  assign prdata = prdata_q;

  // read mux; unimplemented bits are zero because they are never stored
  always_comb begin
    rd_word = 24'h000000;
    case (idx)
      IDX_STATUS: rd_word = st_q | {23'h0, result_pending_flag_q};
      IDX_CFG_A: rd_word = ca_q;
      IDX_CFG_B: rd_word = cb_q;
      IDX_LOCK: rd_word = {lock_q, map_checksum_value_q};
      default: rd_word = 24'h000000;
    endcase
  end

  // read data captured in the setup cycle so it comes from a flop
  always_ff @(posedge clk) begin
    if (!resetn) begin
      prdata_q <= 32'h00000000;
    end else if (psel && !penable) begin
      prdata_q <= {8'h00, rd_word};
    end
  end

  // configuration registers; locked map ignores these writes
  always_ff @(posedge clk) begin
    if (!resetn) begin
      st_q <= ST_RESET;
      ca_q <= CA_RESET;
      cb_q <= CB_RESET;
    end else if (wr && !locked) begin
      // reserved bits 13:12 are stored as written; host keeps them zero
      if (idx == IDX_STATUS) begin
        st_q <= pwdata[23:0] & ST_WMASK;
      end
      if (idx == IDX_CFG_A) begin
        ca_q <= pwdata[23:0] & CA_WMASK;
      end
      if (idx == IDX_CFG_B) begin
        cb_q <= pwdata[23:0] & CB_WMASK;
      end
    end
  end

  // lock key is writable whether locked or not
  always_ff @(posedge clk) begin
    if (!resetn) begin
      lock_q <= LOCK_PASSWORD;
    end else if (wr && idx == IDX_LOCK) begin
      lock_q <= pwdata[23:16];
    end
  end

  // refresh tick counter runs only while locked
  always_ff @(posedge clk) begin
    if (!resetn || !locked) begin
      refresh_q <= 4'd0;
    end else if (modulator_digital_clock_tick) begin
      refresh_q <= (refresh_q == CRC_REFRESH_TICKS - 4'd1) ? 4'd0 : refresh_q + 4'd1;
    end
  end

  // checksum, compare and sticky interrupt; unlocked clears all of it
  always_ff @(posedge clk) begin
    if (!resetn || !locked) begin
      map_checksum_value_q <= CRC_RESET;
      crc_seen_q <= 1'b0;
      irq_q <= 1'b0;
    end else if (modulator_digital_clock_tick && refresh_q == CRC_REFRESH_TICKS - 4'd1) begin
      map_checksum_value_q <= crc_calc;
      crc_seen_q <= 1'b1;
      // a mismatch means the static map got corrupted
      if (crc_seen_q && crc_calc != map_checksum_value_q && st_q[ST_INT_EN]) begin
        irq_q <= 1'b1;
      end
    end
  end

  // conversions are dropped while the channel is held in reset or shutdown
  assign conv_go = conv_done && !cb_q[CB_SRST] && !cb_q[CB_SHDN];

  // gain correction delay; one pending event, the data rate is far lower
  always_ff @(posedge clk) begin
    if (!resetn) begin
      delay_q <= 5'd0;
    end else if (conv_go && ca_q[CA_GAINCAL]) begin
      delay_q <= GAIN_DELAY_TICKS;
    end else if (modulator_digital_clock_tick && delay_q != 5'd0) begin
      delay_q <= delay_q - 5'd1;
    end
  end

  // offset-only path fires at once, gain path after the countdown
  assign ready_evt = (conv_go && !ca_q[CA_GAINCAL]) ||
                     (modulator_digital_clock_tick && delay_q == 5'd1 && !(conv_go && ca_q[CA_GAINCAL]));

  // pending flag: new data wins over the clearing status read
  always_ff @(posedge clk) begin
    if (!resetn) begin
      result_pending_flag_q <= 1'b1;
    end else if (ready_evt) begin
      result_pending_flag_q <= 1'b0;
    end else if (status_read) begin
      result_pending_flag_q <= 1'b1;
    end
  end

  // raw result held from conversion until the ready event formats it
  always_ff @(posedge clk) begin
    if (!resetn) begin
      hold_q <= 24'h000000;
    end else if (conv_go) begin
      hold_q <= conv_result;
    end
  end

  // undelayed path formats the fresh sample, the hold only lands on that same edge
  assign fmt_src = conv_go ? conv_result : hold_q;

  // output coding; 16-bit mode rounds and saturates at the top code
  always_ff @(posedge clk) begin
    if (!resetn) begin
      res_q <= 32'h00000000;
    end else if (ready_evt) begin
      case (st_q[ST_DATA_W+:2])
        2'b11: res_q <= {{8{fmt_src[23]}}, fmt_src};
        2'b10: res_q <= {fmt_src, 8'h00};
        2'b01: res_q <= {8'h00, fmt_src};
        default: begin
          if (fmt_src[23:8] == 16'h7fff || !fmt_src[7]) begin
            res_q <= {16'h0000, fmt_src[23:8]};
          end else begin
            res_q <= {16'h0000, fmt_src[23:8] + 16'h0001};
          end
        end
      endcase
    end
  end

  // link checksum word and address counter, registered for the link side
  always_ff @(posedge clk) begin
    if (!resetn) begin
      crcw_q <= 32'h00000000;
      nrd_q <= MAP_DATA;
      nwr_q <= MAP_DATA;
    end else begin
      crcw_q <= st_q[ST_CRC_W] ? {link_crc, 16'h0000} : {16'h0000, link_crc};
      nrd_q <= next_rd(st_q[ST_RD_INC+:2], link_addr);
      if (!st_q[ST_WR_INC]) begin
        nwr_q <= link_addr;
      end else if (link_addr == MAP_LOCK || link_addr < MAP_MOD) begin
        nwr_q <= MAP_MOD;
      end else begin
        nwr_q <= (link_addr == MAP_GAINCAL) ? MAP_LOCK : link_addr + 5'd1;
      end
    end
  end

  // modulator bitstream retimed before it leaves
  always_ff @(posedge clk) begin
    if (!resetn) begin
      bit_q <= 1'b0;
    end else begin
      bit_q <= modulator_bit;
    end
  end

  // ready pin: checksum alarm first, then ready low, then idle state
  always_comb begin
    if (irq_q) begin
      data_ready_pin_o = 1'b0;
      data_ready_pin_oe = 1'b1;
    end else if (!result_pending_flag_q) begin
      data_ready_pin_o = 1'b0;
      data_ready_pin_oe = 1'b1;
    end else begin
      data_ready_pin_o = st_q[ST_FLOAT];
      data_ready_pin_oe = st_q[ST_FLOAT];
    end
  end

  afe_clock_prescaler #(
    .CNT_W(3)
  ) u_prescaler (
    .clk(clk),
    .resetn(resetn),
    .pre_sel(ca_q[CA_PRE+:2]),
    .tick(analog_master_clock)
  );

  // configuration fanned out to the analog and link logic
  assign bitstream_out_pin_o = bit_q & st_q[ST_MDAT];
  assign bitstream_out_pin_oe = st_q[ST_MDAT];
  assign link_next_read_addr = nrd_q;
  assign link_next_write_addr = nwr_q;
  assign link_crc_word = crcw_q;
  assign link_crc_is_32 = st_q[ST_CRC_W];
  assign link_checksum_enable = st_q[ST_LINK_CRC];
  assign result_word = res_q;
  assign data_width = st_q[ST_DATA_W+:2];
  assign offset_correct_enable = ca_q[CA_OFFCAL];
  assign gain_correct_enable = ca_q[CA_GAINCAL];
  assign noise_injection_strength = ca_q[CA_NOISE_INJECTION_STRENGTH+:2];
  assign bias_current_scale = ca_q[CA_BIAS+:2];
  assign decimation_code = ca_q[CA_OSR+:3];
  assign decimation_ratio = OSR_BASE << ca_q[CA_OSR+:3];
  assign reference_tempco_trim = ca_q[CA_TRIM+:8];
  assign channel_soft_reset = cb_q[CB_SRST];
  assign channel_shutdown = cb_q[CB_SHDN];
  assign external_reference_select = cb_q[CB_VREF];
  assign external_clock_select = cb_q[CB_CLK];

  // checks
  property p_ready_sets;
    @(posedge clk) disable iff (!resetn) ready_evt |=> !result_pending_flag_q;
  endproperty
  a_ready_sets: assert property (p_ready_sets) else $error("ready lost");

  property p_read_clears;
    @(posedge clk) disable iff (!resetn)
      (status_read && !ready_evt) |=> result_pending_flag_q;
  endproperty
  a_read_clears: assert property (p_read_clears) else $error("flag not reset");

  property p_lock_blocks;
    @(posedge clk) disable iff (!resetn)
      (wr && locked && idx != IDX_LOCK) |=> $stable(ca_q) && $stable(st_q) && $stable(cb_q);
  endproperty
  a_lock_blocks: assert property (p_lock_blocks) else $error("write while locked");

  property p_irq_pin;
    @(posedge clk) disable iff (!resetn) irq_q |-> data_ready_pin_oe && !data_ready_pin_o;
  endproperty
  a_irq_pin: assert property (p_irq_pin) else $error("alarm not on pin");

  property p_irq_needs_en;
    @(posedge clk) disable iff (!resetn) $rose(irq_q) |-> $past(st_q[ST_INT_EN]);
  endproperty
  a_irq_needs_en: assert property (p_irq_needs_en) else $error("alarm while off");

  property p_unlock_clears;
    @(posedge clk) disable iff (!resetn)
      (wr && idx == IDX_LOCK && pwdata[23:16] == LOCK_PASSWORD)
        |=> ##1 !irq_q && map_checksum_value_q == CRC_RESET;
  endproperty
  a_unlock_clears: assert property (p_unlock_clears) else $error("unlock kept alarm");

  property p_idle_float;
    @(posedge clk) disable iff (!resetn)
      (result_pending_flag_q && !irq_q) |-> data_ready_pin_oe == st_q[ST_FLOAT];
  endproperty
  a_idle_float: assert property (p_idle_float) else $error("idle pin wrong");

  property p_mdat;
    @(posedge clk) disable iff (!resetn)
      bitstream_out_pin_oe |-> bitstream_out_pin_o == $past(modulator_bit);
  endproperty
  a_mdat: assert property (p_mdat) else $error("bitstream mismatch");

  property p_gain_delay;
    @(posedge clk) disable iff (!resetn)
      (conv_go && ca_q[CA_GAINCAL]) |=> delay_q == GAIN_DELAY_TICKS && !ready_evt;
  endproperty
  a_gain_delay: assert property (p_gain_delay) else $error("gain delay wrong");

  property p_no_delay;
    @(posedge clk) disable iff (!resetn)
      (conv_go && !ca_q[CA_GAINCAL]) |=> !result_pending_flag_q;
  endproperty
  a_no_delay: assert property (p_no_delay) else $error("offset path delayed");

  property p_refresh;
    @(posedge clk) disable iff (!resetn) !locked |=> refresh_q == 4'd0 && !crc_seen_q;
  endproperty
  a_refresh: assert property (p_refresh) else $error("checksum ran unlocked");

  c_status_read: cover property (@(posedge clk) disable iff (!resetn)
    !result_pending_flag_q ##1 status_read);
  c_gain_fire: cover property (@(posedge clk) disable iff (!resetn)
    (delay_q == 5'd1 && modulator_digital_clock_tick) ##1 !result_pending_flag_q);
  c_crc_update: cover property (@(posedge clk) disable iff (!resetn) $rose(crc_seen_q));
endmodule
`default_nettype wire

// ===== tb_top.sv
// self-checking bench for the status and configuration register bank
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  import afe_regs_pkg::*;
  logic clk, resetn, psel, penable, pwrite, pready, pslverr, err, conv_req;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rdat, link_crc_word, result_word;
  logic [23:0] conv_value, conv_result;
  logic [4:0] link_addr, link_next_read_addr, link_next_write_addr;
  logic [15:0] link_crc;
  logic modulator_digital_clock_tick, conv_done, modulator_bit, link_crc_is_32, link_checksum_enable;
  logic data_ready_pin_o, data_ready_pin_oe, bitstream_out_pin_o, bitstream_out_pin_oe;
  logic offset_correct_enable, gain_correct_enable, analog_master_clock, channel_soft_reset;
  logic channel_shutdown, external_reference_select, external_clock_select;
  logic [1:0] data_width, noise_injection_strength, bias_current_scale;
  logic [2:0] decimation_code;
  logic [12:0] decimation_ratio;
  logic [7:0] reference_tempco_trim;
  logic [4:0] rexp [4] = '{5'h0e, 5'h0c, 5'h0f, 5'h0f};
  int n_checks, failures, cycles, ticks;

  afe_front_model model (.clk, .resetn, .conv_req, .conv_value, .modulator_digital_clock_tick, .conv_done,
    .conv_result, .modulator_bit);
  afe_status_config_regs dut (.clk, .resetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .modulator_digital_clock_tick, .conv_done, .conv_result, .modulator_bit,
    .link_addr, .link_crc, .link_next_read_addr, .link_next_write_addr, .link_crc_word,
    .link_crc_is_32, .link_checksum_enable, .result_word, .data_width, .data_ready_pin_o,
    .data_ready_pin_oe, .bitstream_out_pin_o, .bitstream_out_pin_oe, .offset_correct_enable,
    .gain_correct_enable, .noise_injection_strength, .bias_current_scale,
    .analog_master_clock, .decimation_code, .decimation_ratio, .reference_tempco_trim,
    .channel_soft_reset, .channel_shutdown, .external_reference_select,
    .external_clock_select);

  // 100 mhz clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // ticks since the last conversion strobe, and a hang guard
  always @(posedge clk) begin
    ticks <= conv_done ? 0 : ticks + int'(modulator_digital_clock_tick);
    cycles++;
    if (cycles == 20000) begin
      failures++;
      end_sim();
    end
  end

  task automatic end_sim();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // one transfer; an idle cycle follows so psel never drops and rises in one step
  task automatic apb(input logic w, input logic [5:0] idx, input logic [31:0] wd);
    paddr <= {idx, 2'b00};
    pwrite <= w;
    pwdata <= wd;
    psel <= 1'b1;
    @(posedge clk);
    penable <= 1'b1;
    // wait for the answer; only the bench timeout ends a hang
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rdat = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wr(input logic [5:0] idx, input logic [31:0] d);
    apb(1'b1, idx, d);
  endtask
  task automatic rd(input logic [5:0] idx, input logic [31:0] exp);
    apb(1'b0, idx, 32'h0);
    chk("read data", exp, rdat);
  endtask
  task automatic conv(input logic [23:0] v);
    conv_value <= v;
    conv_req <= 1'b1;
    @(posedge clk);
    conv_req <= 1'b0;
    repeat (3) @(posedge clk);
  endtask
  // map checksum, msb first
  function automatic logic [15:0] crc16(input logic [71:0] d);
    logic [15:0] c;
    c = 16'h0;
    for (int i = 71; i >= 0; i--)
      c = {c[14:0], 1'b0} ^ ((c[15] ^ d[i]) ? 16'h8005 : 16'h0);
    return c;
  endfunction

  // main sequence
  initial begin
    int n;
    {psel, penable, pwrite, conv_req} = 4'h0;
    paddr = 8'h0;
    pwdata = 32'h0;
    link_addr = 5'h0e;
    link_crc = 16'h1234;
    conv_value = 24'h0;
    resetn = 1'b0;
    repeat (4) @(posedge clk);
    resetn <= 1'b1;
    rd(IDX_STATUS, 32'h00a10001);
    rd(IDX_CFG_A, 32'h00386050);
    rd(IDX_CFG_B, 32'h00000040);
    rd(IDX_LOCK, 32'h00a50000);
    rd(6'h05, 32'h0);
    chk("slave error", 32'h1, {31'h0, err});
    chk("config outs", {14'h0, decimation_ratio, noise_injection_strength, bias_current_scale,
      external_clock_select}, {14'h0, 13'd256, 5'b11101});
    $display("test reset done");
    wr(IDX_STATUS, 32'h00ffcfff);
    rd(IDX_STATUS, 32'h00f7c801);
    chk("link fields", 32'h1f, {link_crc_is_32, data_width, link_checksum_enable,
      bitstream_out_pin_oe});
    chk("crc word", 32'h12340000, link_crc_word);
    chk("bitstream", {31'h0, ~modulator_bit}, {31'h0, bitstream_out_pin_o});
    for (int k = 0; k < 4; k++) begin
      wr(IDX_STATUS, {8'h0, k[1:0], k[0], 21'h0});
      @(posedge clk); // next-address outputs trail the mode bits by one cycle
      chk("next read", {27'h0, rexp[k]}, {27'h0, link_next_read_addr});
      chk("next write", k[0] ? 32'h0f : 32'h0e, {27'h0, link_next_write_addr});
    end
    chk("crc word", 32'h00001234, link_crc_word);
    chk("bitstream off", 32'h0, {bitstream_out_pin_oe, bitstream_out_pin_o});
    $display("test status fields done");
    wr(IDX_STATUS, 32'h00a10000);
    conv(24'h823456);
    chk("pin", 32'h2, {data_ready_pin_oe, data_ready_pin_o});
    chk("result", 32'h00823456, result_word);
    rd(IDX_STATUS, 32'h00a10000);
    chk("pin float", 32'h0, {31'h0, data_ready_pin_oe});
    rd(IDX_STATUS, 32'h00a10001);
    wr(IDX_STATUS, 32'h00b30000);
    chk("pin high", 32'h3, {data_ready_pin_oe, data_ready_pin_o});
    conv(24'h823456);
    chk("result", 32'hff823456, result_word);
    wr(IDX_STATUS, 32'h00a00000);
    conv(24'h123480);
    chk("result", 32'h00001235, result_word);
    conv(24'h7fffc0);
    chk("result", 32'h00007fff, result_word);
    wr(IDX_STATUS, 32'h00a20000);
    conv(24'h823456);
    chk("result", 32'h82345600, result_word);
    rd(IDX_STATUS, 32'h00a20000);
    $display("test conversion done");
    for (int k = 0; k < 8; k++) begin
      wr(IDX_CFG_A, {10'h0, k[1:0], k[1:0], k[1:0], k[2:0], 13'h0});
      chk("fields", {28'h0, k[1:0], k[1:0]}, {28'h0, noise_injection_strength,
        bias_current_scale});
      chk("ratio", 32 << k, {19'h0, decimation_ratio});
      chk("ratio code", k, {29'h0, decimation_code});
      repeat (8) @(posedge clk);
      n = 0;
      repeat (16) begin
        @(posedge clk);
        n += int'(analog_master_clock);
      end
      chk("clock pulses", 16 >> k[1:0], n);
    end
    wr(IDX_CFG_A, 32'hffffffff);
    rd(IDX_CFG_A, 32'h00ffe0ff);
    chk("cal enables", 32'h3ff, {offset_correct_enable, gain_correct_enable,
      reference_tempco_trim});
    conv(24'h1);
    while (ticks < 23) @(posedge clk);
    chk("pin before delay", 32'h0, {31'h0, data_ready_pin_oe});
    while (ticks < 24) @(posedge clk);
    repeat (2) @(posedge clk);
    chk("pin after delay", 32'h2, {data_ready_pin_oe, data_ready_pin_o});
    rd(IDX_STATUS, 32'h00a20000);
    $display("test config a done");
    wr(IDX_CFG_B, 32'hffffffff);
    rd(IDX_CFG_B, 32'h000101c0);
    chk("channel ctl", 32'hf, {channel_soft_reset, channel_shutdown, external_reference_select,
      external_clock_select});
    for (int k = 0; k < 2; k++) begin
      wr(IDX_CFG_B, k[0] ? 32'h00000100 : 32'h00010000);
      conv(24'h1);
      repeat (120) @(posedge clk);
      chk("pin held off", 32'h0, {31'h0, data_ready_pin_oe});
    end
    wr(IDX_CFG_B, 32'h00000040);
    $display("test config b done");
    wr(IDX_LOCK, 32'h0);
    wr(IDX_CFG_B, 32'h0);
    rd(IDX_CFG_B, 32'h00000040);
    repeat (60) @(posedge clk);
    rd(IDX_LOCK, {16'h0, crc16({24'ha20000, 24'hffe0ff, 24'h000040})});
    chk("no alarm", 32'h0, {31'h0, data_ready_pin_oe});
    wr(IDX_LOCK, 32'h00a50000);
    rd(IDX_LOCK, 32'h00a50000);
    $display("test lock done");
    end_sim();
  end
endmodule
`default_nettype wire
